// *** hdl/adc_link_pkg.sv ***
// shared constants for the serial converter link
`default_nettype none
package adc_link_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int RES_BITS = 12;
   localparam int DOZE_PULSES = 2;
   localparam int SLEEP_PULSES = 4;
   localparam int WAKE_PULSE_NS = 50;
   localparam int WAKE_PULSE_CYC =
      (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DOZE_READY_NS = 350;
   localparam int DOZE_READY_CYC =
      (DOZE_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REQ_GAP_NS = 50;
   localparam int REQ_GAP_CYC =
      (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TRIG_LOW_NS = 120;
   localparam int TRIG_LOW_CYC = TRIG_LOW_NS / CLK_PERIOD_NS;
   localparam int TRIG_LATE_CLKS = 14;
   localparam int MAX_RATE_KHZ = 400;
   localparam int MIN_PERIOD_CYC =
      (1000000 / CLK_PERIOD_NS + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
   localparam int GAP_UNI_NS = 385;
   localparam int GAP_BI_NS = 355;
   localparam int GAP_UNI_CYC =
      (GAP_UNI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_BI_CYC =
      (GAP_BI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC = 20;
   localparam int SAR_STEP_CYC = 4;
   // host wait from trigger rise until the word is ready to clock out
   localparam int SAMPLE_TRIGGER_LEAD_CYC = RES_BITS * SAR_STEP_CYC + 12;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DOZE, PWR_SLEEP} power_e;
endpackage : adc_link_pkg
`default_nettype wire

// *** hdl/adc_link_if.sv ***
// serial link between converter and host
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
   logic sclk;
   logic sampleTrigger;
   logic serialOut;
   logic serialOutEn;
   modport converter (input sclk, input sampleTrigger, output serialOut,
      output serialOutEn);
   modport host (output sclk, output sampleTrigger, input serialOut,
      input serialOutEn);
endinterface : adc_link_if
`default_nettype wire

// *** hdl/adc_serial_conversion_power_ctrl.sv ***
// converter end: conversion, power states and serial result output
// Behaviour
// - rising trigger edge starts a conversion
// - two/four trigger pulses, clock low: doze/sleep
// - clock pulse of 50ns wakes device
// - host waits 350ns after doze wake
// - host waits 50ns request to wake
// - bad wake pulse may hang; doze recovers
// - host drops trigger early, at half of TRIG_LOW_CYC
// - host starts at most 400 kHz
// - host keeps gap 385/355ns after conversion
// - result shifted out on serial clock
// - bipolar mode uses two's complement
// - start edges ignored during conversion
// - successive approximation, MSB to LSB
// - negative supply below ground selects bipolar
`timescale 1ns/1ns
`default_nettype none
module adc_serial_conversion_power_ctrl
   import adc_link_pkg::*;
#(
   parameter int BITS = RES_BITS
) (
   input wire logic clk,
   input wire logic resetn,
   adc_link_if.converter link,
   input wire logic [BITS-1:0] analogInput,
   input wire logic negSupplyBelowGnd,
   output logic busy,
   output logic [1:0] powerState,
   output logic hung
);
   logic [2:0] sclkSync_r, trigSync_r;
   logic [2:0] sclkSync_nxt, trigSync_nxt;
   logic sclkLvl_r, sclkLvl_nxt, trigLvl_r, trigLvl_nxt;
   power_e pwr_r, pwr_nxt;
   logic [2:0] pulseCnt_r, pulseCnt_nxt;
   logic [7:0] highCnt_r, highCnt_nxt;
   logic hung_r, hung_nxt;
   logic sample_trigger_r, sample_trigger_nxt;
   logic [3:0] bitIdx_r, bitIdx_nxt;
   logic [2:0] stepCnt_r, stepCnt_nxt;
   logic [BITS-1:0] sar_r, sar_nxt;
   logic [BITS-1:0] shift_r, shift_nxt;
   logic [3:0] outCnt_r, outCnt_nxt;
   logic dout_r, dout_nxt, doutEn_r, doutEn_nxt;
   logic bipolar_r, bipolar_nxt;
   logic [BITS-1:0] sample_r, sample_nxt;
   logic sclkRise, sclkFall, trigRise, trigFall;

   function automatic logic [BITS-1:0] code_of(input logic [BITS-1:0] v,
      input logic bip);
      code_of = bip ? (v ^ {1'b1, {(BITS-1){1'b0}}}) : v;
   endfunction : code_of

   always_comb begin
      sclkSync_nxt = {sclkSync_r[1:0], link.sclk};
      trigSync_nxt = {trigSync_r[1:0], link.sampleTrigger};
      sclkLvl_nxt = sclkLvl_r;
      trigLvl_nxt = trigLvl_r;
      if (sclkSync_r[2] == sclkSync_r[1]) begin
         sclkLvl_nxt = sclkSync_r[1];
      end
      if (trigSync_r[2] == trigSync_r[1]) begin
         trigLvl_nxt = trigSync_r[1];
      end
   end
   assign sclkRise = sclkLvl_nxt & ~sclkLvl_r;
   assign sclkFall = ~sclkLvl_nxt & sclkLvl_r;
   assign trigRise = trigLvl_nxt & ~trigLvl_r;
   assign trigFall = ~trigLvl_nxt & trigLvl_r;

   // power state and pulse counting
   always_comb begin
      pwr_nxt = pwr_r;
      pulseCnt_nxt = pulseCnt_r;
      highCnt_nxt = highCnt_r;
      hung_nxt = hung_r;
      if (sclkLvl_r && highCnt_r != 8'hFF) begin
         highCnt_nxt = highCnt_r + 8'h01;
      end
      if (sclkRise) begin
         highCnt_nxt = 8'h00;
         pulseCnt_nxt = 3'h0;
      end
      if (sclkFall) begin
         if (pwr_r != PWR_ACTIVE) begin
            if (highCnt_r >= 8'(WAKE_PULSE_CYC)) begin
               pwr_nxt = PWR_ACTIVE;
            end else begin
               hung_nxt = 1'b1;
            end
         end
      end
      if (trigFall && !sclkLvl_r) begin
         pulseCnt_nxt = pulseCnt_r + 3'h1;
         if (pulseCnt_r + 3'h1 == 3'(DOZE_PULSES)) begin
            pwr_nxt = PWR_DOZE;
            hung_nxt = 1'b0;
         end
         if (pulseCnt_r + 3'h1 == 3'(SLEEP_PULSES)) begin
            pwr_nxt = PWR_SLEEP;
            pulseCnt_nxt = 3'h0;
         end
      end
   end

   // conversion and serial output
   always_comb begin
      sample_trigger_nxt = sample_trigger_r;
      bitIdx_nxt = bitIdx_r;
      stepCnt_nxt = stepCnt_r;
      sar_nxt = sar_r;
      shift_nxt = shift_r;
      outCnt_nxt = outCnt_r;
      dout_nxt = dout_r;
      doutEn_nxt = doutEn_r;
      sample_nxt = sample_r;
      bipolar_nxt = negSupplyBelowGnd;
      if (trigRise && !sample_trigger_r && pwr_r == PWR_ACTIVE && !hung_r) begin
         sample_trigger_nxt = 1'b1;
         sar_nxt = '0;
         bitIdx_nxt = 4'(BITS-1);
         stepCnt_nxt = 3'h0;
         sample_nxt = code_of(analogInput, bipolar_r);
      end else if (sample_trigger_r) begin
         stepCnt_nxt = stepCnt_r + 3'h1;
         if (stepCnt_r == 3'(SAR_STEP_CYC-1)) begin
            stepCnt_nxt = 3'h0;
            // trial bit kept when the held code reaches it
            if ((sar_r | (BITS'(1) << bitIdx_r)) <= sample_r) begin
               sar_nxt = sar_r | (BITS'(1) << bitIdx_r);
            end
            if (bitIdx_r == 4'h0) begin
               sample_trigger_nxt = 1'b0;
               shift_nxt = (sar_r | (BITS'(1) << bitIdx_r)) <= sample_r ?
                  (sar_r | (BITS'(1) << bitIdx_r)) : sar_r;
               outCnt_nxt = 4'(BITS);
            end else begin
               bitIdx_nxt = bitIdx_r - 4'h1;
            end
         end
      end
      if (sclkRise) begin
         if (outCnt_r != 4'h0) begin
            dout_nxt = shift_r[BITS-1];
            doutEn_nxt = 1'b1;
            shift_nxt = {shift_r[BITS-2:0], 1'b0};
            outCnt_nxt = outCnt_r - 4'h1;
         end else begin
            doutEn_nxt = 1'b0;
            dout_nxt = 1'b0;
         end
      end
      // the start pulse of a power-down request leaves no word behind
      if (pwr_r != PWR_ACTIVE) begin
         sample_trigger_nxt = 1'b0;
         outCnt_nxt = 4'h0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclkSync_r <= 3'h0;
         trigSync_r <= 3'h0;
         sclkLvl_r <= 1'b0;
         trigLvl_r <= 1'b0;
         pwr_r <= PWR_ACTIVE;
         pulseCnt_r <= 3'h0;
         highCnt_r <= 8'h00;
         hung_r <= 1'b0;
         sample_trigger_r <= 1'b0;
         bitIdx_r <= 4'h0;
         stepCnt_r <= 3'h0;
         sar_r <= '0;
         shift_r <= '0;
         outCnt_r <= 4'h0;
         dout_r <= 1'b0;
         doutEn_r <= 1'b0;
         bipolar_r <= 1'b0;
         sample_r <= '0;
      end else begin
         sclkSync_r <= sclkSync_nxt;
         trigSync_r <= trigSync_nxt;
         sclkLvl_r <= sclkLvl_nxt;
         trigLvl_r <= trigLvl_nxt;
         pwr_r <= pwr_nxt;
         pulseCnt_r <= pulseCnt_nxt;
         highCnt_r <= highCnt_nxt;
         hung_r <= hung_nxt;
         sample_trigger_r <= sample_trigger_nxt;
         bitIdx_r <= bitIdx_nxt;
         stepCnt_r <= stepCnt_nxt;
         sar_r <= sar_nxt;
         shift_r <= shift_nxt;
         outCnt_r <= outCnt_nxt;
         dout_r <= dout_nxt;
         doutEn_r <= doutEn_nxt;
         bipolar_r <= bipolar_nxt;
         sample_r <= sample_nxt;
      end
   end

   assign link.serialOut = dout_r;
   assign link.serialOutEn = doutEn_r;
   assign busy = sample_trigger_r;
   assign powerState = pwr_r;
   assign hung = hung_r;
endmodule : adc_serial_conversion_power_ctrl
`default_nettype wire

// *** hdl/adc_link_host.sv ***
// host end: drives serial clock and trigger, collects results
`timescale 1ns/1ns
`default_nettype none
module adc_link_host
   import adc_link_pkg::*;
#(
   parameter int BITS = RES_BITS,
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   adc_link_if.host link,
   input wire logic convReq,
   input wire logic dozeReq,
   input wire logic sleepReq,
   input wire logic wakeReq,
   input wire logic bipolarMode,
   output logic ready,
   output logic resultValid,
   output logic [BITS-1:0] result
);
   typedef enum logic [2:0] {H_IDLE, H_TRIG, H_GAP, H_SHIFT, H_PULSE,
      H_WAKE, H_WAIT} hstate_e;
   hstate_e st_r, st_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] period_r, period_nxt;
   logic [4:0] bits_r, bits_nxt;
   logic [2:0] pulses_r, pulses_nxt;
   logic sclk_r, sclk_nxt, trig_r, trig_nxt;
   logic [BITS-1:0] rx_r, rx_nxt;
   logic valid_r, valid_nxt;
   logic [BITS-1:0] res_r, res_nxt;
   logic [15:0] gapCyc;

   assign gapCyc = bipolarMode ? 16'(GAP_BI_CYC) : 16'(GAP_UNI_CYC);

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 16'h1;
      period_nxt = (period_r != 16'hFFFF) ? period_r + 16'h1 : period_r;
      bits_nxt = bits_r;
      pulses_nxt = pulses_r;
      sclk_nxt = sclk_r;
      trig_nxt = trig_r;
      rx_nxt = rx_r;
      valid_nxt = 1'b0;
      res_nxt = res_r;
      case (st_r)
         H_IDLE: begin
            cnt_nxt = 16'h0;
            sclk_nxt = 1'b0;
            if (convReq && period_r >= 16'(MIN_PERIOD_CYC)) begin
               trig_nxt = 1'b1;
               period_nxt = 16'h0;
               st_nxt = H_TRIG;
            end else if (dozeReq || sleepReq) begin
               pulses_nxt = dozeReq ? 3'(DOZE_PULSES) : 3'(SLEEP_PULSES);
               trig_nxt = 1'b1;
               st_nxt = H_PULSE;
            end else if (wakeReq) begin
               sclk_nxt = 1'b1;
               st_nxt = H_WAKE;
            end
         end
         H_TRIG: begin
            // trigger dropped at half of TRIG_LOW_CYC, while the conversion runs
            if (cnt_r == 16'(TRIG_LOW_CYC/2)) begin
               trig_nxt = 1'b0;
            end
            // first clock rise only once the word is complete
            if (cnt_r == 16'(SAMPLE_TRIGGER_LEAD_CYC)) begin
               cnt_nxt = 16'h0;
               bits_nxt = 5'h0;
               st_nxt = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (cnt_r == 16'(HALF_CYC-1)) begin
               cnt_nxt = 16'h0;
               sclk_nxt = ~sclk_r;
               if (sclk_r) begin
                  rx_nxt = {rx_r[BITS-2:0], link.serialOut};
                  bits_nxt = bits_r + 5'h1;
                  if (bits_r == 5'(BITS)) begin
                     res_nxt = rx_r;
                     valid_nxt = 1'b1;
                     st_nxt = H_GAP;
                  end
               end
            end
         end
         H_GAP: begin
            if (cnt_r >= gapCyc) begin
               st_nxt = H_IDLE;
            end
         end
         H_PULSE: begin
            if (cnt_r == 16'(HALF_CYC-1)) begin
               cnt_nxt = 16'h0;
               trig_nxt = ~trig_r;
               if (trig_r) begin
                  pulses_nxt = pulses_r - 3'h1;
                  if (pulses_r == 3'h1) begin
                     st_nxt = H_WAIT;
                  end
               end
            end
         end
         H_WAIT: begin
            if (cnt_r >= 16'(REQ_GAP_CYC)) begin
               st_nxt = H_IDLE;
            end
         end
         H_WAKE: begin
            if (cnt_r == 16'(2*WAKE_PULSE_CYC)) begin
               sclk_nxt = 1'b0;
            end
            if (cnt_r >= 16'(DOZE_READY_CYC)) begin
               st_nxt = H_IDLE;
            end
         end
         default: st_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_r <= H_IDLE;
         cnt_r <= 16'h0;
         period_r <= 16'hFFFF;
         bits_r <= 5'h0;
         pulses_r <= 3'h0;
         sclk_r <= 1'b0;
         trig_r <= 1'b0;
         rx_r <= '0;
         valid_r <= 1'b0;
         res_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         period_r <= period_nxt;
         bits_r <= bits_nxt;
         pulses_r <= pulses_nxt;
         sclk_r <= sclk_nxt;
         trig_r <= trig_nxt;
         rx_r <= rx_nxt;
         valid_r <= valid_nxt;
         res_r <= res_nxt;
      end
   end

   assign link.sclk = sclk_r;
   assign link.sampleTrigger = trig_r;
   assign ready = (st_r == H_IDLE);
   assign resultValid = valid_r;
   assign result = res_r;
endmodule : adc_link_host
`default_nettype wire

// *** verif/adc_link_properties.sv ***
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ns
`default_nettype none
module adc_link_properties
   import adc_link_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic sampleTrigger,
   input wire logic serialOut,
   input wire logic serialOutEn
);
   localparam int TLOW = TRIG_LOW_CYC;
   logic sclk_r, sclk_nxt;
   logic [4:0] rise_r, rise_nxt;
   logic [7:0] hi_r, hi_nxt, gap_r, gap_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   always_comb begin
      sclk_nxt = sclk;
      rise_nxt = !serialOutEn ? 5'h0 : rise_r + 5'(sclk && !sclk_r);
      hi_nxt = !sclk ? 8'h0 : hi_r + 8'(hi_r != 8'hFF);
      gap_nxt = serialOutEn ? 8'h0 : gap_r + 8'(gap_r != 8'hFF);
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk_r <= 1'b0;
         rise_r <= 5'h0;
         hi_r <= 8'h0;
         gap_r <= 8'hFF;
      end else begin
         sclk_r <= sclk_nxt;
         rise_r <= rise_nxt;
         hi_r <= hi_nxt;
         gap_r <= gap_nxt;
      end
   end
   property p_out_on_sclk;
      serialOutEn && $past(serialOutEn) && $changed(serialOut)
         |-> $past(sclk, 2) && !$past(sclk, 8);
   endproperty
   a_out_on_sclk: assert property (p_out_on_sclk)
      else $error("data changed away from a clock rise");
   property p_release_on_sclk;
      $fell(serialOutEn) |-> $past(sclk, 2) && !$past(sclk, 8);
   endproperty
   a_release_on_sclk: assert property (p_release_on_sclk)
      else $error("line released away from a clock rise");
   property p_bit_count;
      $fell(serialOutEn) |-> rise_r == RES_BITS || rise_r == RES_BITS + 1;
   endproperty
   a_bit_count: assert property (p_bit_count)
      else $error("wrong number of clock rises in a word");
   property p_quiet_in_trigger;
      sampleTrigger |-> !serialOutEn;
   endproperty
   a_quiet_in_trigger: assert property (p_quiet_in_trigger)
      else $error("line driven while trigger high");
   property p_trig_clock_low;
      $rose(sampleTrigger) |-> !sclk;
   endproperty
   a_trig_clock_low: assert property (p_trig_clock_low)
      else $error("trigger raised with clock high");
   property p_trig_drop;
      $rose(sampleTrigger) |-> ##[1:TLOW] !sampleTrigger;
   endproperty
   a_trig_drop: assert property (p_trig_drop)
      else $error("trigger held high too long");
   property p_clock_width;
      $fell(sclk) |-> hi_r >= WAKE_PULSE_CYC;
   endproperty
   a_clock_width: assert property (p_clock_width)
      else $error("clock pulse too short");
   property p_sample_trigger_gap;
      $rose(sampleTrigger) |-> gap_r >= GAP_BI_CYC;
   endproperty
   a_sample_trigger_gap: assert property (p_sample_trigger_gap)
      else $error("conversion started too soon after a word");
endmodule : adc_link_properties
`default_nettype wire

// *** verif/adc_serial_conversion_power_ctrl_bench.sv ***
// paired-ends bench with a second converter driven by hand
`timescale 1ns/1ns
`default_nettype none
module adc_serial_conversion_power_ctrl_bench;
   import adc_link_pkg::*;
   logic clk, resetn, convReq, dozeReq, sleepReq, wakeReq, bip;
   logic busyA, hungA, busyB, hungB, ready, resultValid;
   logic [1:0] pwrA, pwrB;
   logic [11:0] analogA, analogB, result, word;
   logic [11:0] vals [6] = '{12'h000, 12'hFFF, 12'hA5A, 12'h5A5, 12'h800,
      12'h7FF};
   int n_fail = 0;
   int num_checks = 0;
   int nValid = 0;
   adc_link_if linkA();
   adc_link_if linkB();
   adc_serial_conversion_power_ctrl adc_serial_conversion_power_ctrl_inst (
      .clk(clk), .resetn(resetn), .link(linkA), .analogInput(analogA),
      .negSupplyBelowGnd(bip), .busy(busyA), .powerState(pwrA),
      .hung(hungA));
   adc_serial_conversion_power_ctrl adc_serial_conversion_power_ctrl_b_inst (
      .clk(clk), .resetn(resetn), .link(linkB), .analogInput(analogB),
      .negSupplyBelowGnd(bip), .busy(busyB), .powerState(pwrB),
      .hung(hungB));
   adc_link_host adc_link_host_inst (
      .clk(clk), .resetn(resetn), .link(linkA), .convReq(convReq),
      .dozeReq(dozeReq), .sleepReq(sleepReq), .wakeReq(wakeReq),
      .bipolarMode(bip), .ready(ready), .resultValid(resultValid),
      .result(result));
   adc_link_properties adc_link_properties_inst (
      .clk(clk), .resetn(resetn), .sclk(linkA.sclk),
      .sampleTrigger(linkA.sampleTrigger), .serialOut(linkA.serialOut),
      .serialOutEn(linkA.serialOutEn));
   task automatic give_verdict();
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [11:0] exp,
      input logic [11:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask : check
   // k: 0 convert, 1 wake, 2 doze, 3 sleep; held until the host leaves idle
   task automatic hostOp(input int k);
      int i;
      {sleepReq, dozeReq, wakeReq, convReq} = 4'(1 << k);
      for (i = 0; i < 2000 && ready === 1'b1; i++) @(negedge clk);
      {sleepReq, dozeReq, wakeReq, convReq} = 4'h0;
      for (i = 0; i < 2000 && ready !== 1'b1; i++) @(negedge clk);
      repeat (DOZE_READY_CYC) @(negedge clk);
   endtask : hostOp
   // one pulse of trigger or clock on the hand-driven link, data taken high
   task automatic pulseB(input logic trg, input int hi);
      if (trg) linkB.sampleTrigger = 1'b1;
      else linkB.sclk = 1'b1;
      repeat (hi) @(negedge clk);
      word = {word[10:0], linkB.serialOut};
      linkB.sampleTrigger = 1'b0;
      linkB.sclk = 1'b0;
      repeat (hi) @(negedge clk);
   endtask : pulseB
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(negedge clk) begin
      if (resultValid === 1'b1) nValid++;
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      {resetn, convReq, dozeReq, sleepReq, wakeReq, bip} = 6'h0;
      {analogA, word} = 24'h0;
      analogB = 12'hBC6;
      linkB.sclk = 1'b0;
      linkB.sampleTrigger = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      for (int b = 0; b < 2; b++) begin
         bip = b[0];
         for (int j = 0; j < 6; j++) begin
            analogA = vals[j];
            hostOp(0);
            check("res", vals[j] ^ {b[0], 11'h0}, result);
         end
      end
      bip = 1'b0;
      for (int k = 2; k < 4; k++) begin
         hostOp(k);
         check("pwrA", 12'(k==2 ? PWR_DOZE : PWR_SLEEP), 12'(pwrA));
         hostOp(1);
         check("pwrA", 12'(PWR_ACTIVE), 12'(pwrA));
         check("hungA", 12'h0, 12'(hungA));
         analogA = 12'h321 + 12'(k);
         hostOp(0);
         check("res", 12'h321 + 12'(k), result);
         check("busyA", 12'h0, 12'(busyA));
      end
      pulseB(1'b1, 8);
      check("busyB", 12'h1, 12'(busyB));
      // a clock pulse keeps the two starts from counting as a doze request
      pulseB(1'b0, 4);
      pulseB(1'b1, 8);
      repeat (24) @(negedge clk);
      check("busyB", 12'h0, 12'(busyB));
      for (int j = 0; j < 12; j++) pulseB(1'b0, 20);
      check("word", 12'hBC6, word);
      pulseB(1'b0, 20);
      check("en", 12'h0, 12'(linkB.serialOutEn));
      pulseB(1'b1, 8);
      repeat (60) @(negedge clk);
      pulseB(1'b0, 20);
      pulseB(1'b1, 8);
      repeat (60) @(negedge clk);
      check("pwrB", 12'(PWR_ACTIVE), 12'(pwrB));
      pulseB(1'b0, 20);
      repeat (2) pulseB(1'b1, 8);
      check("pwrB", 12'(PWR_DOZE), 12'(pwrB));
      repeat (REQ_GAP_CYC) @(negedge clk);
      pulseB(1'b0, 5);
      check("hungB", 12'h1, 12'(hungB));
      repeat (2) pulseB(1'b1, 8);
      check("hungB", 12'h0, 12'(hungB));
      repeat (REQ_GAP_CYC) @(negedge clk);
      pulseB(1'b0, 20);
      check("pwrB", 12'(PWR_ACTIVE), 12'(pwrB));
      repeat (4) pulseB(1'b1, 8);
      check("pwrB", 12'(PWR_SLEEP), 12'(pwrB));
      repeat (REQ_GAP_CYC) @(negedge clk);
      pulseB(1'b0, 20);
      check("pwrB", 12'(PWR_ACTIVE), 12'(pwrB));
      check("nValid", 12'h00E, 12'(nValid));
      give_verdict();
   end
endmodule : adc_serial_conversion_power_ctrl_bench
`default_nettype wire
